// *** hw/t2_pkg.sv ***
//Contract
// - 16-bit counter counts machine cycles, or count pin falls when selected.
// - Counter runs only while run_control bit 2 is set; else off.
// - Overflow sets overflow_flag bit 7 unless a serial clock select is set.
// - Trigger fall causing capture or reload sets external_trigger_flag bit 6.
// - Both flags drive one shared interrupt request.
// - Receive clock in serial modes 1 and 3 is this overflow when bit 5 set, else timer 1's.
// - Transmit clock in serial modes 1 and 3 is this overflow when bit 4 set, else timer 1's.
// - Trigger falls act only with enable bit 3 and no serial clocking.
// - Mode is reload, capture or baud from selects while running.
// - Capture copies counter bytes into capture/reload pair; counting continues.
// - Capture mode counts freely and flags every overflow.
// - Reload mode reloads from the pair and flags on rollover.
// - Reload mode also reloads early on trigger fall and sets external flag.
// - Serial clocking ignores capture select and reloads on overflow only.
// - Count pin sampled at phase T9; high then low counts once.
// - Internal tick is one machine cycle, twelve oscillator clocks.
package t2_pkg;

  // Machine cycle length and the phase at which pins are sampled.
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYCLE_DIV = 12;
  localparam int unsigned PHASE_W = 4;
  localparam logic [3:0] SAMPLE_PHASE = 4'h8;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_CNT_LO = 8'hCC;
  localparam logic [7:0] ADDR_CNT_HI = 8'hD0;
  localparam logic [7:0] ADDR_CAP_LO = 8'hD4;
  localparam logic [7:0] ADDR_CAP_HI = 8'hD8;

  // Control register bit positions.
  localparam int unsigned OVF_BIT = 7;
  localparam int unsigned EXF_BIT = 6;
  localparam int unsigned RCLK_BIT = 5;
  localparam int unsigned TX_CLOCK_SELECT_BIT = 4;
  localparam int unsigned EXEN_BIT = 3;
  localparam int unsigned RUN_BIT = 2;
  localparam int unsigned CT_BIT = 1;
  localparam int unsigned CPRL_BIT = 0;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;

  // Operating modes.
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_RELOAD = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_BAUD = 2'b11
  } t2_mode_t;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } t2_avs_req_t;

  // Synchroniser state.
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } t2_sync_t;

  // Timer state.
  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic tick;
    logic cnt_smp;
    logic trg_smp;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [7:0] ctrl;
    logic ack;
    logic wreq;
    logic [31:0] rdata;
    logic irq;
    logic rxc;
    logic txc;
  } t2_state_t;

endpackage : t2_pkg

// *** hw/t2_sync.sv ***
`timescale 1ns/10ps
module t2_sync
  import t2_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Raw pins, bit 0 count pin, bit 1 trigger pin.
  input wire logic [1:0] pins,
  // Synchronised pins.
  output logic [1:0] pins_sync
);

  t2_sync_t r;
  t2_sync_t n;

  // Two flip-flops per pin; only the second stage is read outside.
  always_comb begin
    n = r;
    n.meta = pins;
    n.stable = r.meta;
  end

  // Pins idle high so the first sample sees no false fall.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{meta: 2'h3, stable: 2'h3};
    end else begin
      r <= n;
    end
  end

  assign pins_sync = r.stable;

endmodule : t2_sync

// *** hw/t2_timer.sv ***
`timescale 1ns/10ps
module t2_timer
  import t2_pkg::*;
#(
  parameter int unsigned DIV = CYCLE_DIV
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Avalon-MM register slave.
  input t2_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // External pins.
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  // Serial port clocking.
  input wire logic [1:0] serial_mode,
  input wire logic timer1_overflow,
  output logic rx_baud_clk,
  output logic tx_baud_clk,
  // Shared interrupt request.
  output logic irq_req
);

  t2_state_t r;
  t2_state_t n;
  t2_mode_t mode;
  logic [1:0] pins_s;
  logic run;
  logic baud;
  logic cnt_fall;
  logic trg_fall;
  logic count_en;
  logic ovf;
  logic ext_evt;
  logic take;
  logic wr_lo;
  logic wr_ctrl;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_cap_lo;
  logic wr_cap_hi;
  logic serial13;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // Both pins come from outside and pass two flip-flops first.
  t2_sync u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pins({trigger_pin, count_input_pin}),
    .pins_sync(pins_s)
  );

  // Mode decode from the control bits.
  assign run = r.ctrl[RUN_BIT];
  assign baud = r.ctrl[RCLK_BIT] | r.ctrl[TX_CLOCK_SELECT_BIT];
  always_comb begin
    if (!run) begin
      mode = MODE_OFF;
    end else if (baud) begin
      mode = MODE_BAUD;
    end else if (r.ctrl[CPRL_BIT]) begin
      mode = MODE_CAPTURE;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  // Falls are seen as a high sample then a low one, one machine cycle apart.
  assign cnt_fall = r.tick & r.cnt_smp & ~pins_s[0];
  assign trg_fall = r.tick & r.trg_smp & ~pins_s[1];

  // Count source, overflow and qualified trigger events.
  assign count_en = (mode != MODE_OFF) &
    (r.ctrl[CT_BIT] ? cnt_fall : r.tick);
  assign ovf = count_en & (r.cnt == CNT_TOP);
  assign ext_evt = trg_fall & r.ctrl[EXEN_BIT] &
    ((mode == MODE_RELOAD) | (mode == MODE_CAPTURE));

  // A write lands at the edge where waitrequest is sampled low.
  assign take = avs_req.write & r.ack;
  assign wr_lo = take & avs_req.byteenable[0];
  assign wr_ctrl = wr_lo & (avs_req.address == ADDR_CTRL);
  assign wr_cnt_lo = wr_lo & (avs_req.address == ADDR_CNT_LO);
  assign wr_cnt_hi = wr_lo & (avs_req.address == ADDR_CNT_HI);
  assign wr_cap_lo = wr_lo & (avs_req.address == ADDR_CAP_LO);
  assign wr_cap_hi = wr_lo & (avs_req.address == ADDR_CAP_HI);
  assign wbyte = avs_req.writedata[7:0];
  assign serial13 = serial_mode[0];

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    case (avs_req.address)
      ADDR_CTRL: rbyte = r.ctrl;
      ADDR_CNT_LO: rbyte = r.cnt[7:0];
      ADDR_CNT_HI: rbyte = r.cnt[15:8];
      ADDR_CAP_LO: rbyte = r.cap[7:0];
      ADDR_CAP_HI: rbyte = r.cap[15:8];
      default: rbyte = 8'h00;
    endcase
  end

  // Next state of the whole block.
  always_comb begin
    n = r;
    // Machine cycle prescaler with one tick per cycle.
    if (r.phase == PHASE_W'(DIV - 1)) begin
      n.phase = '0;
    end else begin
      n.phase = r.phase + PHASE_W'(1);
    end
    n.tick = (r.phase == SAMPLE_PHASE);
    if (r.tick) begin
      n.cnt_smp = pins_s[0];
      n.trg_smp = pins_s[1];
    end
    // Counter and capture/reload pair by mode.
    case (mode)
      MODE_RELOAD: begin
        if (ovf || ext_evt) begin
          n.cnt = r.cap;
        end else if (count_en) begin
          n.cnt = r.cnt + 16'h0001;
        end
      end
      MODE_CAPTURE: begin
        if (count_en) begin
          n.cnt = r.cnt + 16'h0001;
        end
        if (ext_evt) begin
          n.cap = r.cnt;
        end
      end
      MODE_BAUD: begin
        if (ovf) begin
          n.cnt = r.cap;
        end else if (count_en) begin
          n.cnt = r.cnt + 16'h0001;
        end
      end
      default: begin
        n.cnt = r.cnt;
      end
    endcase
    // Software byte writes take priority over counting.
    if (wr_cnt_lo) begin
      n.cnt[7:0] = wbyte;
    end
    if (wr_cnt_hi) begin
      n.cnt[15:8] = wbyte;
    end
    if (wr_cap_lo) begin
      n.cap[7:0] = wbyte;
    end
    if (wr_cap_hi) begin
      n.cap[15:8] = wbyte;
    end
    // Control write; hardware flag sets win over a clear.
    if (wr_ctrl) begin
      n.ctrl = wbyte;
    end
    if (ovf && !baud) begin
      n.ctrl[OVF_BIT] = 1'b1;
    end
    if (ext_evt) begin
      n.ctrl[EXF_BIT] = 1'b1;
    end
    // Shared interrupt request from either flag.
    n.irq = r.ctrl[OVF_BIT] | r.ctrl[EXF_BIT];
    // Serial clock pulses, only in serial modes 1 and 3.
    n.rxc = serial13 &
      (r.ctrl[RCLK_BIT] ? ovf : timer1_overflow);
    n.txc = serial13 &
      (r.ctrl[TX_CLOCK_SELECT_BIT] ? ovf : timer1_overflow);
    // Bus handshake: one wait cycle, then one answer cycle.
    n.ack = (avs_req.read | avs_req.write) & ~r.ack;
    n.wreq = ~n.ack;
    n.rdata = (avs_req.read & ~r.ack) ? {24'h000000, rbyte} : 32'h0;
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r <= '{
        phase: '0, tick: 1'b0, cnt_smp: 1'b1, trg_smp: 1'b1,
        cnt: CNT_RST, cap: CAP_RST, ctrl: CTRL_RST, ack: 1'b0,
        wreq: 1'b1, rdata: 32'h0, irq: 1'b0, rxc: 1'b0,
        txc: 1'b0
      };
    end else begin
      r <= n;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.wreq;
  assign rx_baud_clk = r.rxc;
  assign tx_baud_clk = r.txc;
  assign irq_req = r.irq;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Overflow outside serial clocking raises the overflow flag.
  property p_ovf_flag;
    ovf && !baud |=> r.ctrl[OVF_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow flag not set after overflow");

  // Serial clocking never raises the overflow flag by itself.
  property p_baud_no_flag;
    baud && !wr_ctrl && !r.ctrl[OVF_BIT] |=> !r.ctrl[OVF_BIT];
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag)
    else $error("overflow flag set while clocking the serial port");

  // A stopped counter holds its value.
  property p_off_hold;
    !run && !wr_cnt_lo && !wr_cnt_hi |=> $stable(r.cnt);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("counter moved while stopped");

  // A trigger in capture mode copies the counter.
  property p_capture;
    ext_evt && mode == MODE_CAPTURE && !wr_cap_lo && !wr_cap_hi
      |=> r.cap == $past(r.cnt);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture pair does not hold the counter");

  // Rollover or trigger in reload mode loads the pair.
  property p_reload;
    (ovf || ext_evt) && mode == MODE_RELOAD && !wr_cnt_lo && !wr_cnt_hi
      |=> r.cnt == $past(r.cap);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded from the pair");

  // Qualified trigger events raise the external flag.
  property p_exf;
    ext_evt |=> r.ctrl[EXF_BIT];
  endproperty
  a_exf: assert property (p_exf)
    else $error("external flag not set after trigger");

  // Trigger events never act while clocking the serial port.
  property p_ext_masked;
    baud || !r.ctrl[EXEN_BIT] |-> !ext_evt;
  endproperty
  a_ext_masked: assert property (p_ext_masked)
    else $error("trigger acted while masked");

  // Either flag shows on the interrupt one cycle later.
  property p_irq;
    r.ctrl[OVF_BIT] || r.ctrl[EXF_BIT] |=> irq_req;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request missing with a flag set");

  // Receive clock follows this overflow when selected.
  property p_rx_clk;
    serial13 && r.ctrl[RCLK_BIT] && ovf |=> rx_baud_clk;
  endproperty
  a_rx_clk: assert property (p_rx_clk)
    else $error("receive clock pulse missing");

  // Transmit clock follows timer 1 when not selected.
  property p_tx_clk;
    serial13 && !r.ctrl[TX_CLOCK_SELECT_BIT] |=> tx_baud_clk == $past(timer1_overflow);
  endproperty
  a_tx_clk: assert property (p_tx_clk)
    else $error("transmit clock does not follow timer 1");

  // Machine cycle ticks stand apart by at least nine clocks.
  sequence s_quiet;
    !r.tick [*8];
  endsequence
  property p_tick;
    r.tick |=> s_quiet;
  endproperty
  a_tick: assert property (p_tick)
    else $error("machine cycle ticks too close");

  // In timer mode the counter advances only on a tick.
  property p_timer_step;
    run && !r.ctrl[CT_BIT] && !r.tick && !wr_cnt_lo && !wr_cnt_hi
      && !ext_evt |=> $stable(r.cnt);
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("counter moved between machine cycles");

  // A request is answered on the next cycle.
  property p_bus;
    (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus request not answered in one cycle");

endmodule : t2_timer

// *** tb/t2_far.sv ***
`timescale 1ns/10ps
module t2_far (
  // Clock.
  input wire logic ref_clk,
  // Serial clocks from the timer.
  input wire logic rx_baud_clk,
  input wire logic tx_baud_clk,
  // Event pins and timer 1 overflow.
  output logic count_input_pin = 1'b1,
  output logic trigger_pin = 1'b1,
  output logic timer1_overflow = 1'b0
);
  int n_rx = 0;
  int n_tx = 0;
  int n_t1 = 0;
  int t1_div = 0;

  // Timer 1 overflows every 37 clocks; every serial pulse is counted.
  always @(posedge ref_clk) begin
    t1_div <= (t1_div == 36) ? 0 : t1_div + 1;
    timer1_overflow <= (t1_div == 36);
    n_t1 <= n_t1 + timer1_overflow;
    n_rx <= n_rx + rx_baud_clk;
    n_tx <= n_tx + tx_baud_clk;
  end

  // One fall of a pin, low and high for three machine cycles each.
  task automatic fall(input bit trg);
    @(posedge ref_clk);
    if (trg) begin
      trigger_pin <= 1'b0;
    end else begin
      count_input_pin <= 1'b0;
    end
    repeat (36) @(posedge ref_clk);
    trigger_pin <= 1'b1;
    count_input_pin <= 1'b1;
    repeat (36) @(posedge ref_clk);
  endtask : fall
endmodule : t2_far

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench
  import t2_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  t2_avs_req_t avs_req = '0;
  logic [1:0] serial_mode = 2'b00;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic count_input_pin, trigger_pin, timer1_overflow;
  logic rx_baud_clk, tx_baud_clk, irq_req;
  logic [31:0] seed = 32'h41;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int n_tests = 0;
  int i, n, drx, dtx, dt1, erx, etx;
  logic [7:0] v, c;

  t2_timer #(.DIV(CYCLE_DIV)) i_t2_timer (.ref_clk(ref_clk), .reset(reset),
    .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .count_input_pin(count_input_pin),
    .trigger_pin(trigger_pin), .serial_mode(serial_mode),
    .timer1_overflow(timer1_overflow), .rx_baud_clk(rx_baud_clk),
    .tx_baud_clk(tx_baud_clk), .irq_req(irq_req));
  t2_far i_t2_far (.ref_clk(ref_clk), .rx_baud_clk(rx_baud_clk),
    .tx_baud_clk(tx_baud_clk), .count_input_pin(count_input_pin),
    .trigger_pin(trigger_pin), .timer1_overflow(timer1_overflow));

  // Free-running 50 MHz clock.
  always #10 ref_clk = ~ref_clk;

  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Holds one Avalon request until waitrequest is sampled low.
  task bus(input logic rd_en, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_req <= '{rd_en, !rd_en, a, 4'hF, {24'h0, d}};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_req <= '0;
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b1, a, 8'h00);
  endtask : rd

  task wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h04, d[15:8]);
  endtask : wr16

  task rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 8'h04, e[15:8]);
  endtask : rd16

  // Pin events in one mode; f bit j set means the j-th fall is a trigger.
  task ev(input logic [7:0] cr, input logic [15:0] cn, input logic [15:0] cp,
          input logic [2:0] f, input int nf, input logic [15:0] ecn,
          input logic [15:0] ecp, input logic [7:0] ecr);
    wr(ADDR_CTRL, 8'h00);
    wr16(ADDR_CNT_LO, cn);
    wr16(ADDR_CAP_LO, cp);
    wr(ADDR_CTRL, cr);
    for (int j = 0; j < nf; j++) i_t2_far.fall(f[j]);
    rd16(ADDR_CNT_LO, ecn);
    rd16(ADDR_CAP_LO, ecp);
    rd(ADDR_CTRL, ecr);
    check(irq_req, ecr[7] | ecr[6]);
  endtask : ev

  // Compares read data with the oldest noted value at completion.
  always @(posedge ref_clk) begin
    if (avs_req.read && avs_waitrequest === 1'b0) begin
      check(avs_readdata, exp_q.pop_front());
    end
  end

  // Cuts a hung run short.
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (i = 0; i < 6; i++) rd(ADDR_CTRL + 8'(4 * i), 8'h00);
    for (i = 1; i < 6; i++) begin
      v = rnd();
      wr(ADDR_CTRL + 8'(4 * i), v);
      rd(ADDR_CTRL + 8'(4 * i), (i == 5) ? 8'h00 : v);
    end
    ev(8'h0B, 16'h1234, 16'h0000, 3'b010, 2,
       16'h1234, 16'h0000, 8'h0B);
    ev(8'h06, 16'hFFFE, 16'h1234, 3'b000, 2,
       16'h1234, 16'h1234, 8'h86);
    ev(8'h0E, 16'h0100, 16'h2222, 3'b001, 1,
       16'h2222, 16'h2222, 8'h4E);
    ev(8'h06, 16'h0100, 16'h2222, 3'b001, 1,
       16'h0100, 16'h2222, 8'h06);
    ev(8'h0F, 16'h5A5A, 16'h0000, 3'b010, 3,
       16'h5A5C, 16'h5A5B, 8'h4F);
    ev(8'h0F, 16'hFFFF, 16'h0000, 3'b000, 1,
       16'h0000, 16'h0000, 8'h8F);
    ev(8'h3F, 16'hFFFF, 16'hABCD, 3'b001, 2,
       16'hABCD, 16'hABCD, 8'h3F);
    // Serial clocks stay off during set-up, so only the falls are counted.
    for (i = 0; i < 3; i++) begin
      c = (i == 0) ? 8'h26 : 8'h16;
      serial_mode <= 2'b00;
      ev(c, 16'hFFFF, 16'hFFFF, 3'b000, 0, 16'hFFFF, 16'hFFFF, c);
      serial_mode <= (i < 2) ? 2'b01 : 2'b10;
      drx = i_t2_far.n_rx;
      dtx = i_t2_far.n_tx;
      dt1 = i_t2_far.n_t1;
      i_t2_far.fall(1'b0);
      i_t2_far.fall(1'b0);
      drx = i_t2_far.n_rx - drx;
      dtx = i_t2_far.n_tx - dtx;
      dt1 = i_t2_far.n_t1 - dt1;
      rd16(ADDR_CNT_LO, 16'hFFFF);
      rd(ADDR_CTRL, c);
      erx = (i == 2) ? 0 : (c[5] ? 2 : dt1);
      etx = (i == 2) ? 0 : (c[4] ? 2 : dt1);
      check(32'((drx - erx) * (drx - erx) <= (c[5] ? 0 : 1)), 32'h1);
      check(32'((dtx - etx) * (dtx - etx) <= (c[4] ? 0 : 1)), 32'h1);
    end
    wr(ADDR_CTRL, 8'h00);
    wr16(ADDR_CNT_LO, 16'hFFF0);
    wr16(ADDR_CAP_LO, 16'h0000);
    wr(ADDR_CTRL, 8'h04);
    n = 0;
    while (irq_req !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    check(32'(n >= 178 && n <= 200), 32'h1);
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge ref_clk);
    check(irq_req, 1'b0);
    wrap_up();
  end
endmodule : testbench
